// ===== inc/arw_pkg.sv
`default_nettype none
package arw_pkg;
  // Bus and data widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CFG_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] RES_LOW_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] RES_HIGH_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] WAKE_CTRL_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 4'h6;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 4'h7;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_IRQ_EN_BIT = 4;
  // Configuration register fields
  localparam int CFG_LEN_BIT = 7;
  localparam int CFG_ALIGN_BIT = 6;
  // Wakeup control register fields
  localparam int WAKE_EN_BIT = 7;
  localparam int WAKE_FLAG_BIT = 6;
  // Interrupt status, enable and clear layout
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;

  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  typedef enum logic [0:0] {
    ARW_IDLE = 1'b0,
    ARW_BUSY = 1'b1
  } arw_state_t;
endpackage
`default_nettype wire

// ===== inc/arw_conv_if.sv
`timescale 1ns/1ns
`default_nettype none
interface arw_conv_if;
  logic start;
  logic abort;
  logic align;
  logic length;
  logic busy;
  logic done;
  logic [arw_pkg::DATA_W-1:0] res_high;
  logic [arw_pkg::DATA_W-1:0] res_low;

  modport ctl (output start, output abort, output align, output length,
               input busy, input done, input res_high, input res_low);
  modport seq (input start, input abort, input align, input length,
               output busy, output done, output res_high, output res_low);
endinterface
`default_nettype wire

// ===== hdl/arw_conv_seq.sv
`timescale 1ns/1ns
`default_nettype none
module arw_conv_seq (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic conv_done_i,
  input wire logic [arw_pkg::RES_W-1:0] conv_data_i,
  arw_conv_if.seq cif
);
  arw_pkg::arw_state_t state, next_state;
  logic done_s1, done_s2, done_s3;
  logic next_done_s1, next_done_s2, next_done_s3;
  logic [arw_pkg::RES_W-1:0] data_s1, data_s2, next_data_s1, next_data_s2;
  logic [arw_pkg::DATA_W-1:0] res_high, res_low, next_res_high, next_res_low;
  logic done_p, next_done_p;
  logic [15:0] fmt;

  // Places a 12-bit sample into the high and low result bytes
  function automatic logic [15:0] arw_format(input logic [11:0] d, input logic align,
                                             input logic len);
    logic [15:0] r;
    r = 16'h0000;
    if (!align && !len)
      r = {d[11:4], 4'h0, d[3:0]};
    else if (!align && len)
      r = {d[11:4], 6'h00, d[3:2]};
    else if (align && !len)
      r = {4'h0, d[11:8], d[7:0]};
    else
      r = {6'h00, d[11:10], d[9:2]};
    return r;
  endfunction

  always_comb
  begin
    next_done_s1 = conv_done_i;
    next_done_s2 = done_s1;
    next_done_s3 = done_s2;
    next_data_s1 = conv_data_i;
    next_data_s2 = data_s1;
    next_state = state;
    next_done_p = 1'h0;
    next_res_high = res_high;
    next_res_low = res_low;
    fmt = arw_format(data_s2, cif.align, cif.length);
    case (state)
      arw_pkg::ARW_IDLE:
        if (cif.start)
          next_state = arw_pkg::ARW_BUSY;
      arw_pkg::ARW_BUSY:
        if (cif.abort)
          next_state = arw_pkg::ARW_IDLE;
        else if (done_s2 && !done_s3)
        begin
          next_state = arw_pkg::ARW_IDLE;
          next_done_p = 1'h1;
          next_res_high = fmt[15:8];
          next_res_low = fmt[7:0];
        end
      default:
        next_state = arw_pkg::ARW_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state <= arw_pkg::ARW_IDLE;
      done_s1 <= 1'h0;
      done_s2 <= 1'h0;
      done_s3 <= 1'h0;
      data_s1 <= 12'h000;
      data_s2 <= 12'h000;
      done_p <= 1'h0;
      res_high <= arw_pkg::REG_RST;
      res_low <= arw_pkg::REG_RST;
    end
    else
    begin
      state <= next_state;
      done_s1 <= next_done_s1;
      done_s2 <= next_done_s2;
      done_s3 <= next_done_s3;
      data_s1 <= next_data_s1;
      data_s2 <= next_data_s2;
      done_p <= next_done_p;
      res_high <= next_res_high;
      res_low <= next_res_low;
    end
  end

  assign cif.busy = (state == arw_pkg::ARW_BUSY);
  assign cif.done = done_p;
  assign cif.res_high = res_high;
  assign cif.res_low = res_low;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  len_trim_low_a: assert property (done_p && !cif.align && cif.length |-> res_low[7:2] == 6'h00)
    else $error("ten-bit left layout has stray low bits");
  len_trim_high_a: assert property (done_p && cif.align && cif.length |-> res_high[7:2] == 6'h00)
    else $error("ten-bit right layout has stray high bits");
endmodule
`default_nettype wire

// ===== hdl/arw_adc_ctrl.sv
// Behaviour
// - Alignment 0: top eight result bits in high byte, rest in low byte bits 3:0 (length 0) or 1:0 (length 1).
// - Alignment 1: top four or two bits in high byte 3:0, low eight in low byte.
// - Writing 1 to the start bit, with the enable bit 1 in the same write, begins a conversion.
// - Completion shows as start bit 0 or done flag 1; interrupt if enabled.
// - Hardware sets wakeup flag bit 6 on a wakeup event; software clears it.
// - Wakeup flag interrupt uses the same output as conversion completion.
// - With the wakeup module disabled the wakeup flag stays 0.
// - Start bit clears at completion; writing 0 during conversion aborts it.
// - While the done flag is 1, setting the start bit starts nothing.
// - Length setting 1 keeps only the top ten of twelve bits.
`timescale 1ns/1ns
`default_nettype none
module arw_adc_ctrl (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [arw_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [arw_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [arw_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic conv_done_i,
  input wire logic [arw_pkg::RES_W-1:0] conv_data_i,
  input wire logic wake_evt_i,
  output logic conv_enable_o,
  output logic conv_run_o,
  output logic wake_enable_o,
  output logic irq_o
);
  arw_conv_if cif ();

  logic conv_en, next_conv_en;
  logic start_bit, next_start_bit;
  logic done_flag, next_done_flag;
  logic irq_en, next_irq_en;
  logic len_sel, next_len_sel;
  logic align_sel, next_align_sel;
  logic [arw_pkg::DATA_W-1:0] result_low, next_result_low;
  logic [arw_pkg::DATA_W-1:0] result_high, next_result_high;
  logic done_pend, next_done_pend;
  logic wake_en, next_wake_en;
  logic wake_flag, next_wake_flag;
  logic [1:0] irq_mask, next_irq_mask;
  logic [arw_pkg::DATA_W-1:0] rdata, next_rdata;
  logic irq, next_irq;
  logic wake_s1, wake_s2, wake_s3;
  logic next_wake_s1, next_wake_s2, next_wake_s3;
  logic wr_ctrl, sw_start, sw_abort, wake_edge, clr_done, clr_wake;
  logic [1:0] status;

  arw_conv_seq u_seq (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i),
    .cif(cif)
  );

  // True when a register write hits the given offset
  function automatic logic arw_hit(input logic wr, input logic [3:0] addr,
                                   input logic [3:0] ofs);
    return wr && (addr == ofs);
  endfunction

  assign status = {wake_flag, done_flag};
  assign cif.start = sw_start;
  assign cif.abort = sw_abort;
  assign cif.align = align_sel;
  assign cif.length = len_sel;

  // Conversion control, results and flags
  always_comb
  begin
    next_conv_en = conv_en;
    next_start_bit = start_bit;
    next_done_flag = done_flag;
    next_irq_en = irq_en;
    next_len_sel = len_sel;
    next_align_sel = align_sel;
    next_result_low = result_low;
    next_result_high = result_high;
    next_wake_en = wake_en;
    next_wake_flag = wake_flag;
    next_irq_mask = irq_mask;
    next_wake_s1 = wake_evt_i;
    next_wake_s2 = wake_s1;
    next_wake_s3 = wake_s2;
    wake_edge = wake_s2 && !wake_s3;
    wr_ctrl = arw_hit(reg_wr_i, reg_addr_i, arw_pkg::CTRL_OFS);
    // A start needs the converter enabled and the previous done flag cleared
    sw_start = wr_ctrl && reg_wdata_i[arw_pkg::CTRL_START_BIT] && !start_bit
               && reg_wdata_i[arw_pkg::CTRL_EN_BIT] && !done_flag && !done_pend;
    // Writing 0 to the start bit, or disabling the converter, stops a conversion
    sw_abort = wr_ctrl && start_bit && (!reg_wdata_i[arw_pkg::CTRL_START_BIT]
               || !reg_wdata_i[arw_pkg::CTRL_EN_BIT]);
    clr_done = (wr_ctrl && !reg_wdata_i[arw_pkg::CTRL_DONE_BIT])
               || (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::IRQ_CLR_OFS)
                   && reg_wdata_i[arw_pkg::IRQ_DONE_BIT]);
    clr_wake = (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::WAKE_CTRL_OFS)
                && !reg_wdata_i[arw_pkg::WAKE_FLAG_BIT])
               || (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::IRQ_CLR_OFS)
                   && reg_wdata_i[arw_pkg::IRQ_WAKE_BIT]);
    next_done_pend = cif.done;

    if (wr_ctrl)
    begin
      next_conv_en = reg_wdata_i[arw_pkg::CTRL_EN_BIT];
      next_irq_en = reg_wdata_i[arw_pkg::CTRL_IRQ_EN_BIT];
    end
    if (sw_start)
      next_start_bit = 1'h1;
    if (sw_abort || done_pend)
      next_start_bit = 1'h0;
    if (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::CFG_OFS))
    begin
      next_len_sel = reg_wdata_i[arw_pkg::CFG_LEN_BIT];
      next_align_sel = reg_wdata_i[arw_pkg::CFG_ALIGN_BIT];
    end
    if (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::RES_LOW_OFS))
      next_result_low = reg_wdata_i;
    if (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::RES_HIGH_OFS))
      next_result_high = reg_wdata_i;
    // Both bytes load in the same edge; the flag follows one cycle later
    if (cif.done)
    begin
      next_result_low = cif.res_low;
      next_result_high = cif.res_high;
    end
    if (clr_done)
      next_done_flag = 1'h0;
    if (done_pend)
      next_done_flag = 1'h1;
    if (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::WAKE_CTRL_OFS))
      next_wake_en = reg_wdata_i[arw_pkg::WAKE_EN_BIT];
    if (clr_wake)
      next_wake_flag = 1'h0;
    if (wake_edge && wake_en)
      next_wake_flag = 1'h1;
    if (arw_hit(reg_wr_i, reg_addr_i, arw_pkg::IRQ_EN_OFS))
      next_irq_mask = reg_wdata_i[1:0];
    // One request line for both events, gated by the converter interrupt enable
    next_irq = irq_en && |(status & irq_mask);
  end

  // Register read port
  always_comb
  begin
    next_rdata = arw_pkg::REG_RST;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        arw_pkg::CTRL_OFS:
          next_rdata = {conv_en, start_bit, done_flag, irq_en, 4'h0};
        arw_pkg::CFG_OFS:
          next_rdata = {len_sel, align_sel, 6'h00};
        arw_pkg::RES_LOW_OFS:
          next_rdata = result_low;
        arw_pkg::RES_HIGH_OFS:
          next_rdata = result_high;
        arw_pkg::IRQ_STAT_OFS:
          next_rdata = {6'h00, status};
        arw_pkg::IRQ_EN_OFS:
          next_rdata = {6'h00, irq_mask};
        default:
          next_rdata = arw_pkg::REG_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      conv_en <= 1'h0;
      start_bit <= 1'h0;
      done_flag <= 1'h0;
      irq_en <= 1'h0;
      len_sel <= 1'h0;
      align_sel <= 1'h0;
      result_low <= arw_pkg::REG_RST;
      result_high <= arw_pkg::REG_RST;
      done_pend <= 1'h0;
      wake_en <= 1'h0;
      wake_flag <= 1'h0;
      irq_mask <= arw_pkg::IRQ_MASK_RST;
      wake_s1 <= 1'h0;
      wake_s2 <= 1'h0;
      wake_s3 <= 1'h0;
      rdata <= arw_pkg::REG_RST;
      irq <= 1'h0;
    end
    else
    begin
      conv_en <= next_conv_en;
      start_bit <= next_start_bit;
      done_flag <= next_done_flag;
      irq_en <= next_irq_en;
      len_sel <= next_len_sel;
      align_sel <= next_align_sel;
      result_low <= next_result_low;
      result_high <= next_result_high;
      done_pend <= next_done_pend;
      wake_en <= next_wake_en;
      wake_flag <= next_wake_flag;
      irq_mask <= next_irq_mask;
      wake_s1 <= next_wake_s1;
      wake_s2 <= next_wake_s2;
      wake_s3 <= next_wake_s3;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  assign reg_rdata_o = rdata;
  assign conv_enable_o = conv_en;
  assign conv_run_o = cif.busy;
  assign wake_enable_o = wake_en;
  assign irq_o = irq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence result_loaded_s;
    cif.done ##1 !done_flag || $stable(done_flag);
  endsequence

  sequence flag_raised_s;
    ##1 done_flag && !start_bit;
  endsequence

  left_align_a: assert property (cif.done && !align_sel |=>
      result_high == $past(cif.res_high) && result_low[7:4] == 4'h0)
    else $error("left aligned result bytes wrong");

  right_align_a: assert property (cif.done && align_sel |=>
      result_low == $past(cif.res_low) && result_high[7:4] == 4'h0)
    else $error("right aligned result bytes wrong");

  start_begins_a: assert property (sw_start && !cif.busy |=> start_bit && cif.busy)
    else $error("start write did not begin a conversion");

  done_irq_a: assert property (done_flag && irq_en && irq_mask[0] |=> irq)
    else $error("completion interrupt missing");

  wake_set_a: assert property (wake_edge && wake_en && !clr_wake |=> wake_flag)
    else $error("wakeup event did not set its flag");

  wake_irq_a: assert property (wake_flag && irq_en && irq_mask[1] |=> irq)
    else $error("wakeup flag did not reach the interrupt line");

  wake_gate_a: assert property ($rose(wake_flag) |-> $past(wake_en))
    else $error("wakeup flag set while module disabled");

  abort_stops_a: assert property (sw_abort |=> !cif.busy && !start_bit)
    else $error("start bit clear did not stop the conversion");

  done_clears_a: assert property (cif.done |=> ##1 !start_bit)
    else $error("start bit not cleared at completion");

  flag_blocks_a: assert property (wr_ctrl && reg_wdata_i[6] && done_flag && !cif.busy
      |=> !cif.busy)
    else $error("conversion started while done flag set");

  result_first_a: assert property (result_loaded_s |-> flag_raised_s)
    else $error("done flag did not follow the result load");

  sticky_flag_a: assert property (done_flag && !clr_done |=> done_flag)
    else $error("done flag dropped without a software clear");

  run_has_bit_a: assert property (cif.busy |->
      start_bit)
    else $error("conversion running with start bit clear");

  start_sets_a: assert property (sw_start && !done_pend |=>
      start_bit)
    else $error("accepted start did not set the start bit");

  rd_ctrl_a: assert property (reg_rd_i && reg_addr_i == arw_pkg::CTRL_OFS |=>
      rdata[6:5] == $past({start_bit, done_flag}))
    else $error("control read lost start bit or done flag");

  irq_gate_a: assert property (!irq_en |=>
      !irq)
    else $error("interrupt raised with converter interrupt disabled");

  irq_source_a: assert property (irq |->
      $past(|(status & irq_mask)))
    else $error("interrupt raised without an enabled flag");

  wake_quiet_a: assert property (!wake_en && !wake_flag |=>
      !wake_flag)
    else $error("disabled wakeup module raised its flag");

  wake_clear_a: assert property ($fell(wake_flag) |->
      $past(clr_wake))
    else $error("wakeup flag dropped without a software clear");

  bit_fall_a: assert property ($fell(start_bit) |->
      $past(sw_abort || done_pend))
    else $error("start bit dropped without completion or abort");

  en_abort_a: assert property (wr_ctrl && start_bit && !reg_wdata_i[7] |=>
      !cif.busy)
    else $error("disabling the converter did not stop the conversion");

  sequence abort_req_s;
    sw_abort ##1 !cif.busy;
  endsequence

  abort_quiet_a: assert property (abort_req_s |=>
      !cif.done)
    else $error("aborted conversion still completed");

  flag_no_start_a: assert property (done_flag |->
      !start_bit)
    else $error("start bit set while done flag pending");

  pair_load_a: assert property (cif.done |=>
      result_high == $past(cif.res_high) && result_low == $past(cif.res_low))
    else $error("result bytes not loaded together");

  flag_rise_a: assert property ($rose(done_flag) |->
      $past(done_pend))
    else $error("done flag rose before the result load");

  flag_fall_a: assert property ($fell(done_flag) |->
      $past(clr_done))
    else $error("done flag cleared without a software write");

  rd_result_a: assert property (reg_rd_i && reg_addr_i == arw_pkg::RES_LOW_OFS |=>
      rdata == $past(result_low))
    else $error("low result read returned wrong data");

  rd_idle_a: assert property (!reg_rd_i |=>
      rdata == arw_pkg::REG_RST)
    else $error("read data not zero outside a read");
endmodule
`default_nettype wire

// ===== dv/adc_result_and_wakeup_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adc_result_and_wakeup_ctrl_tb_top;
  logic clk_sys_i;
  logic sys_rst_i;
  logic [arw_pkg::ADDR_W-1:0] reg_addr_i;
  logic [arw_pkg::DATA_W-1:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [arw_pkg::DATA_W-1:0] reg_rdata_o;
  logic conv_done_i;
  logic [arw_pkg::RES_W-1:0] conv_data_i;
  logic wake_evt_i;
  logic conv_enable_o;
  logic conv_run_o;
  logic wake_enable_o;
  logic irq_o;
  int error_cnt;
  int total_checks;
  int cycle_cnt;

  arw_adc_ctrl u_arw_adc_ctrl (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i),
    .wake_evt_i(wake_evt_i),
    .conv_enable_o(conv_enable_o),
    .conv_run_o(conv_run_o),
    .wake_enable_o(wake_enable_o),
    .irq_o(irq_o)
  );

  always #50 clk_sys_i = ~clk_sys_i;

  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Guards against a hung handshake or poll
  always @(posedge clk_sys_i)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 5000)
    begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= addr;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    data = reg_rdata_o;
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    rd(addr, d);
    check(d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Reset values, read-only, write-only and unmapped places
  task automatic test_reset_map();
    for (int a = 0; a < 9; a++)
    begin
      rd_chk(4'(a), 8'h00);
    end
    check({4'h0, conv_enable_o, conv_run_o, wake_enable_o, irq_o}, 8'h00);
    wr(arw_pkg::RES_LOW_OFS, 8'h5A);
    wr(arw_pkg::RES_HIGH_OFS, 8'hA5);
    rd_chk(arw_pkg::RES_LOW_OFS, 8'h5A);
    rd_chk(arw_pkg::RES_HIGH_OFS, 8'hA5);
    wr(arw_pkg::IRQ_STAT_OFS, 8'hFF);
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h00);
  endtask

  // One full conversion with start, poll, fetch, refused restart and clear
  task automatic run_conv(input logic [7:0] cfg, input logic [11:0] data,
                          input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] d;
    int n;
    wr(arw_pkg::CFG_OFS, cfg);
    conv_data_i <= data;
    wr(arw_pkg::CTRL_OFS, 8'hD0);
    check({7'h0, conv_run_o}, 8'h01);
    check({7'h0, conv_enable_o}, 8'h01);
    idle(3);
    check({7'h0, conv_run_o}, 8'h01);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    n = 0;
    d = 8'h00;
    while (d[5] !== 1'b1 && n < 20)
    begin
      rd(arw_pkg::CTRL_OFS, d);
      n++;
    end
    check(d & 8'h60, 8'h20);
    check({7'h0, conv_run_o}, 8'h00);
    check({7'h0, irq_o}, 8'h01);
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h01);
    rd_chk(arw_pkg::RES_HIGH_OFS, hi);
    rd_chk(arw_pkg::RES_LOW_OFS, lo);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    wr(arw_pkg::CTRL_OFS, 8'hF0);
    check({7'h0, conv_run_o}, 8'h00);
    idle(2);
    check({7'h0, conv_run_o}, 8'h00);
    rd_chk(arw_pkg::CTRL_OFS, 8'hB0);
    if (cfg[6])
    begin
      wr(arw_pkg::IRQ_CLR_OFS, 8'h01);
    end
    else
    begin
      wr(arw_pkg::CTRL_OFS, 8'h90);
    end
    idle(2);
    check({7'h0, irq_o}, 8'h00);
    rd_chk(arw_pkg::CTRL_OFS, 8'h90);
  endtask

  // Alignment and length combinations
  task automatic test_layouts();
    wr(arw_pkg::IRQ_EN_OFS, 8'h01);
    run_conv(8'h00, 12'hABC, 8'hAB, 8'h0C);
    run_conv(8'h40, 12'hABC, 8'h0A, 8'hBC);
    run_conv(8'h80, 12'hABC, 8'hAB, 8'h03);
    run_conv(8'hC0, 12'hABC, 8'h02, 8'hAF);
    run_conv(8'h40, 12'h5F3, 8'h05, 8'hF3);
  endtask

  // Clearing the start bit in mid-conversion abandons it
  task automatic test_abort();
    wr(arw_pkg::RES_HIGH_OFS, 8'h11);
    conv_data_i <= 12'h123;
    wr(arw_pkg::CTRL_OFS, 8'hD0);
    check({7'h0, conv_run_o}, 8'h01);
    wr(arw_pkg::CTRL_OFS, 8'h90);
    check({7'h0, conv_run_o}, 8'h00);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    idle(8);
    rd_chk(arw_pkg::CTRL_OFS, 8'h90);
    rd_chk(arw_pkg::RES_HIGH_OFS, 8'h11);
    check({7'h0, irq_o}, 8'h00);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    wr(arw_pkg::CTRL_OFS, 8'hD0);
    check({7'h0, conv_run_o}, 8'h01);
    wr(arw_pkg::CTRL_OFS, 8'h50);
    check({7'h0, conv_run_o}, 8'h00);
    check({7'h0, conv_enable_o}, 8'h00);
  endtask

  task automatic pulse_wake();
    @(posedge clk_sys_i);
    wake_evt_i <= 1'b1;
    idle(3);
    @(posedge clk_sys_i);
    wake_evt_i <= 1'b0;
    idle(6);
  endtask

  // Wakeup flag, its masking and both ways of clearing it
  task automatic test_wakeup();
    wr(arw_pkg::IRQ_EN_OFS, 8'h02);
    pulse_wake();
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h00);
    check({7'h0, irq_o}, 8'h00);
    wr(arw_pkg::WAKE_CTRL_OFS, 8'h80);
    check({7'h0, wake_enable_o}, 8'h01);
    rd_chk(arw_pkg::WAKE_CTRL_OFS, 8'h00);
    pulse_wake();
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h02);
    check({7'h0, irq_o}, 8'h01);
    wr(arw_pkg::IRQ_EN_OFS, 8'h01);
    idle(2);
    check({7'h0, irq_o}, 8'h00);
    wr(arw_pkg::WAKE_CTRL_OFS, 8'h80);
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h00);
    wr(arw_pkg::IRQ_EN_OFS, 8'h02);
    pulse_wake();
    check({7'h0, irq_o}, 8'h01);
    wr(arw_pkg::CTRL_OFS, 8'h00);
    idle(2);
    check({7'h0, irq_o}, 8'h00);
    wr(arw_pkg::IRQ_CLR_OFS, 8'h02);
    rd_chk(arw_pkg::IRQ_STAT_OFS, 8'h00);
    wr(arw_pkg::WAKE_CTRL_OFS, 8'h00);
    check({7'h0, wake_enable_o}, 8'h00);
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    sys_rst_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    conv_done_i = 1'b0;
    conv_data_i = 12'h000;
    wake_evt_i = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cycle_cnt = 0;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    test_reset_map();
    test_layouts();
    test_abort();
    test_wakeup();
    stop_test();
  end
endmodule
`default_nettype wire
